// File: rtl/refresh_timer_parity_ctrl.sv
// refresh interval timer and data bus parity control, AXI4-Lite slave
// assumes a 16-bit data bus port facing memory and area select inputs
// Behaviour
// - counter low byte equal constant sets flag
// - flag clears by read-one then write-zero
// - irq asserted when flag and enable set
// - clock select picks one of seven dividers
// - counter counts up on selected clock
// - match resets counter to zero
// - refresh enable gives refresh request per match
// - upper byte of counter, constant reads zero
// - power-on reset zeroes counter and refresh control
// - power-on reset loads constant with FF
// - parity error sets parity error flag
// - parity flag clears by read then write-zero
// - force bit drives both parity pins high
// - polarity bit chooses even or odd parity
// - space field chooses checked memory areas
// - power-on reset zeroes parity control
// - protected registers accept word writes only
// - upper byte key gates protected writes
// - word read returns zero upper byte
// - refresh disabled gives plain interval timer
// - power-on reset zeroes timer status
`timescale 1ns/10ps
`include "refresh_defines.svh"
module refresh_timer_parity_ctrl (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // axi4-lite write address
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [3:0] s_axi_awaddr_in,
  // axi4-lite write data
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  // axi4-lite write response
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  // axi4-lite read address
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [3:0] s_axi_araddr_in,
  // axi4-lite read data
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  // memory data path, same clock
  input wire logic data_out_phase_in,
  input wire logic data_in_phase_in,
  input wire logic dram_area_in,
  input wire logic area2_in,
  input wire logic [15:0] mem_wdata_in,
  input wire logic [15:0] mem_rdata_in,
  input wire logic parity_pin_upper_in,
  input wire logic parity_pin_lower_in,
  // parity pins out
  output logic parity_pin_upper_out,
  output logic parity_pin_lower_out,
  output logic parity_pin_oe_n_out,
  // refresh and interrupt
  output logic refresh_req_out,
  output logic match_irq_out
);
  import refresh_pkg::*;

  function automatic logic par_bit(input logic [7:0] b, input logic odd);
    par_bit = ^b ^ odd;
  endfunction : par_bit

  ////////////////////////////////////////////////////////////////////////
  // register state
  logic refresh_enable;
  logic [7:0] refresh_ctl_q;
  logic match_flag_q, match_irq_enable_q;
  logic [2:0] count_clock_select_q;
  logic [7:0] refresh_counter_q, refresh_constant_q;
  logic parity_error_flag_q, parity_force_high_q, parity_polarity_q;
  parity_space_t parity_space_q;
  logic match_flag_seen_q, parity_flag_seen_q;
  logic tick, match, par_err, check_space;
  logic wr_par_any;

  ////////////////////////////////////////////////////////////////////////
  // axi write path
  bus_state_t wstate_q;
  logic aw_held_q, w_held_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire, word_wr;
  logic [7:0] key, low;

  assign s_axi_awready_out = (wstate_q == BUS_IDLE) && !aw_held_q;
  assign s_axi_wready_out = (wstate_q == BUS_IDLE) && !w_held_q;
  assign wr_fire = (wstate_q == BUS_IDLE) && aw_held_q && w_held_q;
  assign word_wr = (wstrb_q[1:0] == 2'b11);
  assign key = wdata_q[15:8];
  assign low = wdata_q[7:0];

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_in;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata_in;
        wstrb_q <= s_axi_wstrb_in;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wstate_q <= BUS_IDLE;
      s_axi_bresp_out <= `AXI_OKAY;
    end else begin
      case (wstate_q)
        BUS_IDLE: begin
          if (wr_fire) begin
            wstate_q <= BUS_WRESP;
            s_axi_bresp_out <= (awaddr_q[1:0] == 2'h0) ? `AXI_OKAY : `AXI_SLVERR;
          end
        end
        BUS_WRESP: begin
          if (s_axi_bready_in) begin
            wstate_q <= BUS_IDLE;
          end
        end
        default: wstate_q <= BUS_IDLE;
      endcase
    end
  end
  assign s_axi_bvalid_out = (wstate_q == BUS_WRESP);
  // per-register write strobes with key check
  logic wr_ctl, wr_sts, wr_cnt, wr_cor;
  assign wr_ctl = wr_fire && word_wr && awaddr_q == `OFS_REFRESH_CONTROL && key == `KEY_REFRESH_CONTROL;
  assign wr_sts = wr_fire && word_wr && awaddr_q == `OFS_REFRESH_STATUS && key == `KEY_REFRESH_STATUS;
  assign wr_cnt = wr_fire && word_wr && awaddr_q == `OFS_REFRESH_COUNTER && key == `KEY_REFRESH_COUNTER;
  assign wr_cor = wr_fire && word_wr && awaddr_q == `OFS_REFRESH_CONSTANT && key == `KEY_REFRESH_CONSTANT;

  ////////////////////////////////////////////////////////////////////////
  // axi read path
  bus_state_t rstate_q;
  logic [15:0] rd_word;
  logic [3:0] araddr;
  logic rd_fire;
  assign s_axi_arready_out = (rstate_q == BUS_IDLE);
  assign s_axi_rvalid_out = (rstate_q == BUS_RDATA);
  assign rd_fire = s_axi_arvalid_in && s_axi_arready_out;
  assign araddr = s_axi_araddr_in;

  always_comb begin
    case (araddr)
      `OFS_REFRESH_CONTROL: rd_word = {8'h00, refresh_ctl_q};
      `OFS_REFRESH_STATUS: rd_word = {8'h00, match_flag_q, match_irq_enable_q, count_clock_select_q, 3'h0};
      `OFS_REFRESH_COUNTER: rd_word = {8'h00, refresh_counter_q};
      `OFS_REFRESH_CONSTANT: rd_word = {8'h00, refresh_constant_q};
      default: rd_word = 16'h0000;
    endcase
  end

  // parity control lives in the upper half of the status word
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rstate_q <= BUS_IDLE;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= `AXI_OKAY;
    end else begin
      case (rstate_q)
        BUS_IDLE: begin
          if (rd_fire) begin
            rstate_q <= BUS_RDATA;
            s_axi_rdata_out <= (araddr == `OFS_REFRESH_STATUS)
              ? {parity_error_flag_q, parity_force_high_q, parity_polarity_q, parity_space_q, 11'h000, rd_word}
              : {16'h0000, rd_word};
            s_axi_rresp_out <= (araddr[1:0] == 2'h0) ? `AXI_OKAY : `AXI_SLVERR;
          end
        end
        BUS_RDATA: begin
          if (s_axi_rready_in) begin
            rstate_q <= BUS_IDLE;
          end
        end
        default: rstate_q <= BUS_IDLE;
      endcase
    end
  end

  // a read that sees a flag at one arms its clear
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      match_flag_seen_q <= 1'b0;
      parity_flag_seen_q <= 1'b0;
    end else begin
      if (rd_fire && araddr == `OFS_REFRESH_STATUS && match_flag_q) begin
        match_flag_seen_q <= 1'b1;
      end else if (wr_sts || !match_flag_q) begin
        match_flag_seen_q <= 1'b0;
      end
      if (rd_fire && araddr == `OFS_REFRESH_STATUS && parity_error_flag_q) begin
        parity_flag_seen_q <= 1'b1;
      end else if (wr_par_any || !parity_error_flag_q) begin
        parity_flag_seen_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // parity control writes: upper half of status word, no key, upper strobes
  assign wr_par_any = wr_fire && awaddr_q == `OFS_REFRESH_STATUS && wstrb_q[3:2] == 2'b11;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      parity_error_flag_q <= 1'b0;
      parity_force_high_q <= 1'b0;
      parity_polarity_q <= 1'b0;
      parity_space_q <= SPACE_NONE;
    end else begin
      if (wr_par_any) begin
        parity_force_high_q <= wdata_q[16 + `BIT_PAR_FORCE];
        parity_polarity_q <= wdata_q[16 + `BIT_PAR_POL];
        parity_space_q <= parity_space_t'({wdata_q[16 + `BIT_PAR_SPACE_HI], wdata_q[16 + `BIT_PAR_SPACE_LO]});
      end
      if (par_err) begin
        parity_error_flag_q <= 1'b1;
      end else if (wr_par_any && parity_flag_seen_q && !wdata_q[16 + `BIT_PAR_ERR]) begin
        parity_error_flag_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // refresh control and timer status
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      refresh_ctl_q <= 8'h00;
    end else if (wr_ctl) begin
      refresh_ctl_q <= {low[7:4], 4'h0};
    end
  end
  assign refresh_enable = refresh_ctl_q[`BIT_REFRESH_EN];
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      match_flag_q <= 1'b0;
      match_irq_enable_q <= 1'b0;
      count_clock_select_q <= 3'h0;
    end else begin
      if (wr_sts) begin
        match_irq_enable_q <= low[`BIT_MATCH_IRQ_EN];
        count_clock_select_q <= low[5:3];
      end
      if (match) begin
        match_flag_q <= 1'b1;
      end else if (wr_sts && match_flag_seen_q && !low[`BIT_MATCH_FLAG]) begin
        match_flag_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter and constant
  refresh_prescaler #(
    .DIV_W(`DIV_WIDTH)
  ) u_prescaler (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .select_in(count_clock_select_q),
    .tick_out(tick)
  );

  assign match = (refresh_counter_q == refresh_constant_q) && tick;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      refresh_counter_q <= 8'h00;
    end else if (wr_cnt) begin
      refresh_counter_q <= low;
    end else if (match) begin
      refresh_counter_q <= 8'h00;
    end else if (tick) begin
      refresh_counter_q <= refresh_counter_q + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      refresh_constant_q <= `RST_CONSTANT;
    end else if (wr_cor) begin
      refresh_constant_q <= low;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      refresh_req_out <= 1'b0;
    end else begin
      refresh_req_out <= match && refresh_enable;
    end
  end
  assign match_irq_out = match_flag_q && match_irq_enable_q;

  ////////////////////////////////////////////////////////////////////////
  // parity generation and checking per byte lane
  always_comb begin
    case (parity_space_q)
      SPACE_DRAM: check_space = dram_area_in;
      SPACE_DRAM_AREA2: check_space = dram_area_in || area2_in;
      default: check_space = 1'b0;
    endcase
  end

  assign par_err = data_in_phase_in && check_space &&
    ((par_bit(mem_rdata_in[15:8], parity_polarity_q) != parity_pin_upper_in) ||
     (par_bit(mem_rdata_in[7:0], parity_polarity_q) != parity_pin_lower_in));

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      parity_pin_upper_out <= 1'b0;
      parity_pin_lower_out <= 1'b0;
      parity_pin_oe_n_out <= 1'b1;
    end else begin
      parity_pin_oe_n_out <= !(data_out_phase_in && check_space);
      parity_pin_upper_out <= parity_force_high_q | par_bit(mem_wdata_in[15:8], parity_polarity_q);
      parity_pin_lower_out <= parity_force_high_q | par_bit(mem_wdata_in[7:0], parity_polarity_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_irq_level: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    match && match_irq_enable_q && !wr_sts |=> match_irq_out) else $error("irq not raised on match");
  a_match_sets_flag: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    match && !wr_cnt |=> match_flag_q && refresh_counter_q == 8'h00) else $error("match did not set flag");
  a_flag_clear_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $fell(match_flag_q) |-> $past(match_flag_seen_q)) else $error("flag cleared without read");
  a_refresh_gate: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    refresh_req_out |-> $past(refresh_enable) && match_flag_q) else $error("refresh without enable");
  a_counter_step: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    tick && !match && !wr_cnt |=> refresh_counter_q == $past(refresh_counter_q) + 8'h01)
    else $error("counter did not step");
  a_stopped_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    count_clock_select_q == 3'h0 && !wr_cnt |=> $stable(refresh_counter_q)) else $error("stopped counter moved");
  a_key_bad_nowrite: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    wr_fire && awaddr_q == `OFS_REFRESH_CONSTANT && key != `KEY_REFRESH_CONSTANT
    |=> $stable(refresh_constant_q)) else $error("constant written without key");
  a_par_error_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    par_err |=> parity_error_flag_q) else $error("parity error lost");
  a_force_high: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    parity_force_high_q |=> parity_pin_upper_out && parity_pin_lower_out) else $error("force not high");
endmodule : refresh_timer_parity_ctrl

// File: rtl/refresh_defines.svh
// constants for the refresh timer and parity control block
// assumes inclusion by bare name from the rtl folder
`ifndef REFRESH_DEFINES_SVH
`define REFRESH_DEFINES_SVH
`define OFS_REFRESH_CONTROL 4'h0
`define OFS_REFRESH_STATUS 4'h4
`define OFS_REFRESH_COUNTER 4'h8
`define OFS_REFRESH_CONSTANT 4'hC
`define KEY_REFRESH_CONTROL 8'h5A
`define KEY_REFRESH_STATUS 8'hA5
`define KEY_REFRESH_COUNTER 8'h69
`define KEY_REFRESH_CONSTANT 8'h96
`define RST_CONSTANT 8'hFF
`define BIT_MATCH_FLAG 7
`define BIT_MATCH_IRQ_EN 6
`define BIT_REFRESH_EN 7
`define BIT_PAR_ERR 15
`define BIT_PAR_FORCE 14
`define BIT_PAR_POL 13
`define BIT_PAR_SPACE_HI 12
`define BIT_PAR_SPACE_LO 11
`define DIV_WIDTH 12
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// File: rtl/refresh_pkg.sv
// types shared by the refresh timer block
// assumes the defines header sits beside it
package refresh_pkg;
  typedef enum logic [1:0] {
    SPACE_NONE = 2'b00,
    SPACE_DRAM = 2'b01,
    SPACE_DRAM_AREA2 = 2'b10,
    SPACE_RESERVED = 2'b11
  } parity_space_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRESP = 2'b01,
    BUS_RDATA = 2'b10
  } bus_state_t;
endpackage : refresh_pkg

// File: rtl/refresh_prescaler.sv
// prescaler giving one-cycle count enables from the system clock
// assumes one clock, asynchronous active-low reset
`timescale 1ns/10ps
`include "refresh_defines.svh"
module refresh_prescaler #(
  parameter int DIV_W = `DIV_WIDTH
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // selection
  input wire logic [2:0] select_in,
  // enable pulse
  output logic tick_out
);
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] mask;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_q <= '0;
    end else if (select_in == 3'h0) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // divide by 2,8,32,128,512,2048,4096
  always_comb begin
    case (select_in)
      3'h1: mask = DIV_W'(12'h001);
      3'h2: mask = DIV_W'(12'h007);
      3'h3: mask = DIV_W'(12'h01F);
      3'h4: mask = DIV_W'(12'h07F);
      3'h5: mask = DIV_W'(12'h1FF);
      3'h6: mask = DIV_W'(12'h7FF);
      3'h7: mask = DIV_W'(12'hFFF);
      default: mask = '0;
    endcase
  end

  assign tick_out = (select_in != 3'h0) && ((div_q & mask) == mask);
endmodule : refresh_prescaler

// File: tb/tb.sv
// self-checking bench for the refresh timer and parity control block
// assumes the rtl folder on the include path, one 125 MHz clock
`timescale 1ns/10ps
`include "refresh_defines.svh"
module tb;
  import refresh_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, par_up, par_lo, par_oe_n, refresh_req, match_irq;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic out_ph = 1'b0, in_ph = 1'b0, dram_a = 1'b0, area2 = 1'b0, pin_u = 1'b0, pin_l = 1'b0;
  logic [15:0] mwd = 16'h0, mrd = 16'h0;
  int num_errors = 0;
  int checks = 0;

  always #4 sys_clk = ~sys_clk;

  refresh_timer_parity_ctrl refresh_timer_parity_ctrl_inst (
    .sys_clk_in(sys_clk), .rst_n_in(rst_n),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_araddr_in(araddr),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .data_out_phase_in(out_ph), .data_in_phase_in(in_ph), .dram_area_in(dram_a), .area2_in(area2),
    .mem_wdata_in(mwd), .mem_rdata_in(mrd), .parity_pin_upper_in(pin_u), .parity_pin_lower_in(pin_l),
    .parity_pin_upper_out(par_up), .parity_pin_lower_out(par_lo), .parity_pin_oe_n_out(par_oe_n),
    .refresh_req_out(refresh_req), .match_irq_out(match_irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (num_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int n;
    @(posedge sys_clk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= s; bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 100) chk("write response", 32'h1, 32'h0);
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge sys_clk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 100) chk("read response", 32'h1, 32'h0);
  endtask : axi_rd

  // keyed word write and plain read-compare helpers
  task automatic wkey(input logic [3:0] a, input logic [7:0] key, input logic [7:0] v);
    logic [1:0] r;
    axi_wr(a, {16'h0, key, v}, 4'h3, r);
  endtask : wkey

  task automatic rchk(input string what, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(what, exp, d);
    chk("read response", `AXI_OKAY, r);
  endtask : rchk

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values;
    rchk("refresh_control", `OFS_REFRESH_CONTROL, 32'h0);
    rchk("status and parity_control", `OFS_REFRESH_STATUS, 32'h0);
    rchk("refresh_counter", `OFS_REFRESH_COUNTER, 32'h0);
    rchk("refresh_constant", `OFS_REFRESH_CONSTANT, 32'h0000_00FF);
  endtask : t_reset_values

  task automatic t_keys;
    logic [1:0] r;
    wkey(`OFS_REFRESH_COUNTER, `KEY_REFRESH_COUNTER, 8'hAB);
    rchk("counter keyed", `OFS_REFRESH_COUNTER, 32'h0000_00AB);
    wkey(`OFS_REFRESH_COUNTER, 8'h68, 8'h11);
    rchk("counter bad key", `OFS_REFRESH_COUNTER, 32'h0000_00AB);
    axi_wr(`OFS_REFRESH_COUNTER, {16'h0, `KEY_REFRESH_COUNTER, 8'h22}, 4'h1, r);
    rchk("counter byte write", `OFS_REFRESH_COUNTER, 32'h0000_00AB);
    wkey(`OFS_REFRESH_CONSTANT, `KEY_REFRESH_STATUS, 8'h05);
    rchk("constant wrong key", `OFS_REFRESH_CONSTANT, 32'h0000_00FF);
    wkey(`OFS_REFRESH_COUNTER, `KEY_REFRESH_COUNTER, 8'h00);
    wkey(`OFS_REFRESH_CONSTANT, `KEY_REFRESH_CONSTANT, 8'h01);
    rchk("constant keyed", `OFS_REFRESH_CONSTANT, 32'h0000_0001);
    wkey(`OFS_REFRESH_CONTROL, `KEY_REFRESH_CONTROL, 8'h80);
    rchk("refresh_control keyed", `OFS_REFRESH_CONTROL, 32'h0000_0080);
    axi_wr(4'h2, 32'h0, 4'h3, r);
    chk("misaligned bresp", `AXI_SLVERR, r);
  endtask : t_keys

  // interval between refresh pulses is (constant + 1) ticks of the selected divider
  task automatic t_dividers;
    int div[7] = '{2, 8, 32, 128, 512, 2048, 4096};
    int n;
    int gap;
    for (int s = 1; s <= 7; s++) begin
      wkey(`OFS_REFRESH_STATUS, `KEY_REFRESH_STATUS, {2'b00, 3'(s), 3'b000});
      for (int k = 0; k < 2; k++) begin
        for (n = 0; n < 9000 && refresh_req !== 1'b1; n++) @(posedge sys_clk);
        @(posedge sys_clk);
      end
      for (gap = 1; gap < 9000 && refresh_req !== 1'b1; gap++) @(posedge sys_clk);
      chk("refresh interval", 2 * div[s - 1], gap);
    end
  endtask : t_dividers

  task automatic t_flag_irq;
    int pulses = 0;
    wkey(`OFS_REFRESH_CONTROL, `KEY_REFRESH_CONTROL, 8'h00);
    wkey(`OFS_REFRESH_STATUS, `KEY_REFRESH_STATUS, 8'h08);
    repeat (30) begin
      @(posedge sys_clk);
      if (refresh_req === 1'b1) pulses++;
      chk("irq while disabled", 32'h0, match_irq);
    end
    chk("refresh pulses while disabled", 32'h0, pulses);
    wkey(`OFS_REFRESH_STATUS, `KEY_REFRESH_STATUS, 8'h48);
    repeat (10) @(posedge sys_clk);
    chk("irq level", 32'h1, match_irq);
    wkey(`OFS_REFRESH_STATUS, `KEY_REFRESH_STATUS, 8'h40);
    rchk("flag kept without read", `OFS_REFRESH_STATUS, 32'h0000_00C0);
    wkey(`OFS_REFRESH_STATUS, `KEY_REFRESH_STATUS, 8'h40);
    rchk("flag cleared", `OFS_REFRESH_STATUS, 32'h0000_0040);
    chk("irq after clear", 32'h0, match_irq);
  endtask : t_flag_irq

  ////////////////////////////////////////////////////////////////////////////
  task automatic pout(input logic [15:0] d, input logic dr, input logic a2, input logic oe_n, input logic [1:0] p);
    @(posedge sys_clk);
    out_ph <= 1'b1; mwd <= d; dram_a <= dr; area2 <= a2;
    @(posedge sys_clk);
    out_ph <= 1'b0;
    #1;
    chk("parity oe_n", oe_n, par_oe_n);
    if (oe_n === 1'b0) chk("parity pins", p, {par_up, par_lo});
  endtask : pout

  task automatic pctl(input logic [15:0] v);
    logic [1:0] r;
    axi_wr(`OFS_REFRESH_STATUS, {v, 16'h0}, 4'hC, r);
  endtask : pctl

  task automatic t_parity;
    pctl(16'h0000);
    pout(16'h0301, 1'b1, 1'b0, 1'b1, 2'b00);
    pctl(16'h0800);
    pout(16'h0301, 1'b1, 1'b0, 1'b0, 2'b01);
    pout(16'h0301, 1'b0, 1'b1, 1'b1, 2'b00);
    pctl(16'h3000);
    pout(16'h0301, 1'b0, 1'b1, 1'b0, 2'b10);
    pctl(16'h5000);
    pout(16'h0301, 1'b0, 1'b1, 1'b0, 2'b11);
    pctl(16'h0800);
    rchk("parity reserved bits", `OFS_REFRESH_STATUS, 32'h0800_0040);
    // even parity over each lane: matching pins then a wrong upper pin
    @(posedge sys_clk);
    in_ph <= 1'b1; dram_a <= 1'b1; area2 <= 1'b0; mrd <= 16'h0301; pin_u <= 1'b0; pin_l <= 1'b1;
    @(posedge sys_clk);
    in_ph <= 1'b0;
    rchk("no parity error", `OFS_REFRESH_STATUS, 32'h0800_0040);
    @(posedge sys_clk);
    in_ph <= 1'b1; pin_u <= 1'b1;
    @(posedge sys_clk);
    in_ph <= 1'b0;
    repeat (2) @(posedge sys_clk);
    pctl(16'h0800);
    rchk("error kept without read", `OFS_REFRESH_STATUS, 32'h8800_0040);
    pctl(16'h0800);
    rchk("error cleared", `OFS_REFRESH_STATUS, 32'h0800_0040);
  endtask : t_parity

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(8 * 60000);
    num_errors++;
    end_of_test();
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset_values();
    t_keys();
    t_dividers();
    t_flag_irq();
    t_parity();
    end_of_test();
  end
endmodule : tb
